// ---- hw/lfs_pkg.sv ----
package lfs_pkg;

    // Register bus geometry
    localparam int          LFS_ADDR_W        = 4;
    localparam int          LFS_DATA_W        = 32;
    localparam int          LFS_RATE_W        = 8;

    // Register indices on the plain register port
    localparam logic [3:0]  LFS_REG_CTRL      = 4'h0;
    localparam logic [3:0]  LFS_REG_START     = 4'h1;
    localparam logic [3:0]  LFS_REG_END       = 4'h2;
    localparam logic [3:0]  LFS_REG_RSTEP     = 4'h3;
    localparam logic [3:0]  LFS_REG_FSTEP     = 4'h4;
    localparam logic [3:0]  LFS_REG_RATES     = 4'h5;
    localparam logic [3:0]  LFS_REG_FREQ      = 4'h6;
    localparam logic [3:0]  LFS_REG_STATUS    = 4'h7;

    // Control register bit positions
    localparam int          LFS_BIT_SWEEP_EN  = 21;
    localparam int          LFS_BIT_FORCE_LD  = 15;
    localparam int          LFS_BIT_NO_DWELL  = 2;

    // Rate register field positions
    localparam int          LFS_RISE_RATE_LSB = 0;
    localparam int          LFS_FALL_RATE_LSB = 8;
    localparam int          LFS_RATES_W       = 16;

    // Reset values
    localparam logic [31:0] LFS_CTRL_RESET    = 32'h0000_0000;
    localparam logic [31:0] LFS_WORD_RESET    = 32'h0000_0000;
    localparam logic [15:0] LFS_RATES_RESET   = 16'h0000;

    // Timing: sync output clock toggles once per enabled system cycle
    localparam int          LFS_CLK_PERIOD_NS = 8;
    localparam int          LFS_SYNC_DIV      = 2;

    typedef enum logic [2:0] {
        LFS_ST_SINGLE = 3'b000,
        LFS_ST_RISE   = 3'b001,
        LFS_ST_TOP    = 3'b010,
        LFS_ST_FALL   = 3'b011,
        LFS_ST_BOTTOM = 3'b100
    } lfs_state_t;

endpackage

// ---- hw/lfs_timer_if.sv ----
`timescale 1ns/1ps
interface lfs_timer_if #(
    parameter int RATE_W = 8
);
    logic              run;
    logic              force_load;
    logic [RATE_W-1:0] load_value;
    logic [RATE_W-1:0] reload_value;
    logic              tick;

    modport timer (
        input  run,
        input  force_load,
        input  load_value,
        input  reload_value,
        output tick
    );

    modport ctrl (
        output run,
        output force_load,
        output load_value,
        output reload_value,
        input  tick
    );
endinterface

// ---- hw/lfs_rate_timer.sv ----
`timescale 1ns/1ps
module lfs_rate_timer #(
    parameter int RATE_W = 8
) (
    input  wire logic   clk_sys_i,
    input  wire logic   reset_i,
    input  wire logic   ce_i,
    lfs_timer_if.timer  tmr
);

    if (RATE_W < 1 || RATE_W > 16) begin : g_chk
        $error("lfs_rate_timer: RATE_W must be 1..16");
    end

    logic [RATE_W-1:0] count;
    logic [RATE_W-1:0] next_count;
    logic              at_one;

    // A rate word of zero behaves as one: a step every cycle
    assign at_one   = (count <= RATE_W'(1));
    // Run and forced-load gating stay with the caller, so no loop closes through it
    assign tmr.tick = at_one;

    always_comb begin
        next_count = count;
        if (tmr.force_load) begin
            next_count = tmr.load_value;
        end else if (tmr.run) begin
            if (at_one) begin
                next_count = tmr.reload_value;
            end else begin
                next_count = count - RATE_W'(1);
            end
        end
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            count <= '0;
        end else if (ce_i) begin
            count <= next_count;
        end
    end

endmodule

// ---- hw/lfs_sweep.sv ----
// Operation
// - Sweep only while enable bit 21 set
// - Up: add rising step per rising rate
// - Down: subtract falling step per falling rate
// - Pin rise: rising sweep, load rising rate
// - Up stops at end word, holds
// - Pin fall: falling sweep, hold at start
// - No-dwell: at end jump to start
// - No-dwell: up only, falls ignored
// - Transfers only on strobe rising edge
// - Reset leaves single tone, sweep off
// - Timer counts to one, then reloads
// - Bit 15: strobe force-loads timer
// - Enable set force-loads timer
// - Strobe sampled on sync clock rise
`timescale 1ns/1ps
module lfs_sweep
    import lfs_pkg::*;
(
    input  wire logic                  clk_sys_i,
    input  wire logic                  reset_i,
    input  wire logic                  ce_i,
    input  wire logic [LFS_ADDR_W-1:0] reg_addr_i,
    input  wire logic [LFS_DATA_W-1:0] reg_wdata_i,
    input  wire logic                  reg_wr_i,
    input  wire logic                  reg_rd_i,
    output logic      [LFS_DATA_W-1:0] reg_rdata_o,
    input  wire logic                  profile_select_0_i,
    input  wire logic                  register_transfer_strobe_i,
    output logic                       sync_output_clock_o,
    output logic      [LFS_DATA_W-1:0] freq_word_o,
    output logic                       sweeping_o
);

    // Buffered (software-facing) copies
    logic [31:0]            buf_ctrl;
    logic [31:0]            buf_start;
    logic [31:0]            buf_end;
    logic [31:0]            buf_rstep;
    logic [31:0]            buf_fstep;
    logic [LFS_RATES_W-1:0] buf_rates;
    logic [31:0]            next_buf_ctrl;
    logic [31:0]            next_buf_start;
    logic [31:0]            next_buf_end;
    logic [31:0]            next_buf_rstep;
    logic [31:0]            next_buf_fstep;
    logic [LFS_RATES_W-1:0] next_buf_rates;

    // Working copies that steer the sweep
    logic [31:0]            control_function_reg_one;
    logic [31:0]            start_tuning_word;
    logic [31:0]            end_tuning_word;
    logic [31:0]            rising_step_word;
    logic [31:0]            falling_step_word;
    logic [LFS_RATES_W-1:0] rate_words;
    logic [31:0]            next_control_function_reg_one;
    logic [31:0]            next_start_tuning_word;
    logic [31:0]            next_end_tuning_word;
    logic [31:0]            next_rising_step_word;
    logic [31:0]            next_falling_step_word;
    logic [LFS_RATES_W-1:0] next_rate_words;

    logic [31:0]            next_reg_rdata;
    logic                   next_sync_output_clock;
    logic                   strobe_prev;
    logic                   next_strobe_prev;
    logic                   transfer;

    lfs_state_t             state;
    lfs_state_t             next_state;
    logic [31:0]            acc;
    logic [31:0]            next_acc;
    logic                   ps0_prev;
    logic                   enable_prev;
    logic                   next_sweeping;

    logic [LFS_RATE_W-1:0]  rising_rate_word;
    logic [LFS_RATE_W-1:0]  falling_rate_word;
    logic                   sweep_en;
    logic                   no_dwell;
    logic                   force_on_xfer;
    logic                   ps0_rise;
    logic                   ps0_fall;
    logic [32:0]            up_sum;
    logic [32:0]            down_diff;

    lfs_timer_if #(.RATE_W(LFS_RATE_W)) tmr_if ();

    lfs_rate_timer #(
        .RATE_W (LFS_RATE_W)
    ) u_timer (
        .clk_sys_i (clk_sys_i),
        .reset_i   (reset_i),
        .ce_i      (ce_i),
        .tmr       (tmr_if.timer)
    );

    assign rising_rate_word  = rate_words[LFS_RISE_RATE_LSB +: LFS_RATE_W];
    assign falling_rate_word = rate_words[LFS_FALL_RATE_LSB +: LFS_RATE_W];
    assign sweep_en          = control_function_reg_one[LFS_BIT_SWEEP_EN];
    assign no_dwell          = control_function_reg_one[LFS_BIT_NO_DWELL];
    assign force_on_xfer     = control_function_reg_one[LFS_BIT_FORCE_LD];
    assign ps0_rise          = profile_select_0_i && !ps0_prev;
    assign ps0_fall          = !profile_select_0_i && ps0_prev;
    assign up_sum            = {1'b0, acc} + {1'b0, rising_step_word};
    assign down_diff         = {1'b0, acc} - {1'b0, falling_step_word};

    // Strobe is looked at only when the sync clock is about to rise
    assign transfer = !sync_output_clock_o && register_transfer_strobe_i && !strobe_prev;

    always_comb begin
        next_buf_ctrl                 = buf_ctrl;
        next_buf_start                = buf_start;
        next_buf_end                  = buf_end;
        next_buf_rstep                = buf_rstep;
        next_buf_fstep                = buf_fstep;
        next_buf_rates                = buf_rates;
        next_control_function_reg_one = control_function_reg_one;
        next_start_tuning_word        = start_tuning_word;
        next_end_tuning_word          = end_tuning_word;
        next_rising_step_word         = rising_step_word;
        next_falling_step_word        = falling_step_word;
        next_rate_words               = rate_words;
        next_reg_rdata                = '0;
        next_sync_output_clock        = !sync_output_clock_o;
        next_strobe_prev              = strobe_prev;
        if (!sync_output_clock_o) begin
            next_strobe_prev = register_transfer_strobe_i;
        end
        if (reg_wr_i) begin
            unique case (reg_addr_i)
                LFS_REG_CTRL:  next_buf_ctrl  = reg_wdata_i;
                LFS_REG_START: next_buf_start = reg_wdata_i;
                LFS_REG_END:   next_buf_end   = reg_wdata_i;
                LFS_REG_RSTEP: next_buf_rstep = reg_wdata_i;
                LFS_REG_FSTEP: next_buf_fstep = reg_wdata_i;
                LFS_REG_RATES: next_buf_rates = reg_wdata_i[LFS_RATES_W-1:0];
                default:       next_buf_ctrl  = buf_ctrl;
            endcase
        end
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                LFS_REG_CTRL:   next_reg_rdata = buf_ctrl;
                LFS_REG_START:  next_reg_rdata = buf_start;
                LFS_REG_END:    next_reg_rdata = buf_end;
                LFS_REG_RSTEP:  next_reg_rdata = buf_rstep;
                LFS_REG_FSTEP:  next_reg_rdata = buf_fstep;
                LFS_REG_RATES:  next_reg_rdata = {16'h0000, buf_rates};
                LFS_REG_FREQ:   next_reg_rdata = acc;
                LFS_REG_STATUS: next_reg_rdata = {28'h0000000, sweeping_o, state};
                default:        next_reg_rdata = '0;
            endcase
        end
        // Profile pin toggles never reach this path
        if (transfer) begin
            next_control_function_reg_one = buf_ctrl;
            next_start_tuning_word        = buf_start;
            next_end_tuning_word          = buf_end;
            next_rising_step_word         = buf_rstep;
            next_falling_step_word        = buf_fstep;
            next_rate_words               = buf_rates;
        end
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            buf_ctrl                 <= LFS_CTRL_RESET;
            buf_start                <= LFS_WORD_RESET;
            buf_end                  <= LFS_WORD_RESET;
            buf_rstep                <= LFS_WORD_RESET;
            buf_fstep                <= LFS_WORD_RESET;
            buf_rates                <= LFS_RATES_RESET;
            control_function_reg_one <= LFS_CTRL_RESET;
            start_tuning_word        <= LFS_WORD_RESET;
            end_tuning_word          <= LFS_WORD_RESET;
            rising_step_word         <= LFS_WORD_RESET;
            falling_step_word        <= LFS_WORD_RESET;
            rate_words               <= LFS_RATES_RESET;
            reg_rdata_o              <= '0;
            sync_output_clock_o      <= 1'b0;
            strobe_prev              <= 1'b0;
        end else if (ce_i) begin
            buf_ctrl                 <= next_buf_ctrl;
            buf_start                <= next_buf_start;
            buf_end                  <= next_buf_end;
            buf_rstep                <= next_buf_rstep;
            buf_fstep                <= next_buf_fstep;
            buf_rates                <= next_buf_rates;
            control_function_reg_one <= next_control_function_reg_one;
            start_tuning_word        <= next_start_tuning_word;
            end_tuning_word          <= next_end_tuning_word;
            rising_step_word         <= next_rising_step_word;
            falling_step_word        <= next_falling_step_word;
            rate_words               <= next_rate_words;
            reg_rdata_o              <= next_reg_rdata;
            sync_output_clock_o      <= next_sync_output_clock;
            strobe_prev              <= next_strobe_prev;
        end
    end

    // Sweep engine
    always_comb begin
        next_state              = state;
        next_acc                = acc;
        tmr_if.run              = sweep_en;
        tmr_if.force_load       = 1'b0;
        tmr_if.load_value       = profile_select_0_i ? rising_rate_word : falling_rate_word;
        tmr_if.reload_value     = (state == LFS_ST_FALL) ? falling_rate_word : rising_rate_word;
        if (state == LFS_ST_TOP || state == LFS_ST_BOTTOM) begin
            tmr_if.reload_value = profile_select_0_i ? rising_rate_word : falling_rate_word;
        end
        if (!sweep_en) begin
            next_state = LFS_ST_SINGLE;
            next_acc   = start_tuning_word;
        end else if (!enable_prev) begin
            next_state        = LFS_ST_BOTTOM;
            next_acc          = start_tuning_word;
            tmr_if.force_load = 1'b1;
        end else begin
            if (transfer && force_on_xfer) begin
                tmr_if.force_load = 1'b1;
            end
            if (ps0_rise) begin
                next_state        = LFS_ST_RISE;
                tmr_if.force_load = 1'b1;
                tmr_if.load_value = rising_rate_word;
            end else if (ps0_fall && !no_dwell) begin
                next_state        = LFS_ST_FALL;
                tmr_if.force_load = 1'b1;
                tmr_if.load_value = falling_rate_word;
            end else if (tmr_if.tick && !tmr_if.force_load) begin
                unique case (state)
                    LFS_ST_RISE: begin
                        // Clamp guards against stepping past the end word
                        if (up_sum[32] || up_sum[31:0] >= end_tuning_word) begin
                            if (no_dwell) begin
                                next_acc   = start_tuning_word;
                                next_state = LFS_ST_BOTTOM;
                            end else begin
                                next_acc   = end_tuning_word;
                                next_state = LFS_ST_TOP;
                            end
                        end else begin
                            next_acc = up_sum[31:0];
                        end
                    end
                    LFS_ST_FALL: begin
                        if (down_diff[32] || down_diff[31:0] <= start_tuning_word) begin
                            next_acc   = start_tuning_word;
                            next_state = LFS_ST_BOTTOM;
                        end else begin
                            next_acc = down_diff[31:0];
                        end
                    end
                    LFS_ST_SINGLE,
                    LFS_ST_TOP,
                    LFS_ST_BOTTOM: next_acc = acc;
                    default:       next_state = LFS_ST_SINGLE;
                endcase
            end
        end
        next_sweeping = (next_state == LFS_ST_RISE) || (next_state == LFS_ST_FALL);
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            state       <= LFS_ST_SINGLE;
            acc         <= LFS_WORD_RESET;
            ps0_prev    <= 1'b0;
            enable_prev <= 1'b0;
            sweeping_o  <= 1'b0;
        end else if (ce_i) begin
            state       <= next_state;
            acc         <= next_acc;
            ps0_prev    <= profile_select_0_i;
            enable_prev <= sweep_en;
            sweeping_o  <= next_sweeping;
        end
    end

    assign freq_word_o = acc;

endmodule

// ---- testbench/lfs_sweep_checker.sv ----
`timescale 1ns/1ps
module lfs_sweep_checker
    import lfs_pkg::*;
(
    input wire logic                  clk_sys_i,
    input wire logic                  reset_i,
    input wire logic                  ce_i,
    input wire logic [LFS_ADDR_W-1:0] reg_addr_i,
    input wire logic [LFS_DATA_W-1:0] reg_wdata_i,
    input wire logic                  reg_wr_i,
    input wire logic                  reg_rd_i,
    input wire logic [LFS_DATA_W-1:0] reg_rdata_o,
    input wire logic                  profile_select_0_i,
    input wire logic                  register_transfer_strobe_i,
    input wire logic                  sync_output_clock_o,
    input wire logic [LFS_DATA_W-1:0] freq_word_o,
    input wire logic                  sweeping_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    logic [LFS_DATA_W-1:0] ctl_buf;
    logic [LFS_DATA_W-1:0] ctl_work;
    logic                  strobe_q;
    logic                  sw_en;
    logic                  nd;
    // Shadow control word; may lead the device by a cycle, hence the slack below
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            ctl_buf  <= '0;
            ctl_work <= '0;
            strobe_q <= 1'b0;
        end else if (ce_i) begin
            strobe_q <= register_transfer_strobe_i;
            if (reg_wr_i && reg_addr_i == LFS_REG_CTRL)
                ctl_buf <= reg_wdata_i;
            if (register_transfer_strobe_i && !strobe_q)
                ctl_work <= ctl_buf;
        end
    end
    assign sw_en = ctl_work[LFS_BIT_SWEEP_EN];
    assign nd    = ctl_work[LFS_BIT_NO_DWELL];
    property p_sync_toggle;
        ce_i |=> sync_output_clock_o != $past(sync_output_clock_o);
    endproperty
    a_sync_toggle: assert property (p_sync_toggle) else $error("sync clock stuck");
    property p_disabled;
        !sw_en |-> !sweeping_o;
    endproperty
    a_disabled: assert property (p_disabled) else $error("sweeping while disabled");
    property p_rise_start;
        sw_en && $rose(profile_select_0_i) |-> ##[1:2] sweeping_o;
    endproperty
    a_rise_start: assert property (p_rise_start) else $error("no upward sweep");
    property p_fall_start;
        sw_en && !nd && $fell(profile_select_0_i) |-> ##[1:2] sweeping_o;
    endproperty
    a_fall_start: assert property (p_fall_start) else $error("no downward sweep");
    property p_nd_fall;
        sw_en && nd && $fell(profile_select_0_i) && sweeping_o |=> sweeping_o;
    endproperty
    a_nd_fall: assert property (p_nd_fall) else $error("sweep aborted by pin fall");
    property p_hold_top;
        sw_en && $past(sw_en, 3) && !nd && !sweeping_o && profile_select_0_i && $stable(profile_select_0_i)
            |=> $stable(freq_word_o);
    endproperty
    a_hold_top: assert property (p_hold_top) else $error("end frequency not held");
    property p_hold_bottom;
        sw_en && $past(sw_en, 3) && !sweeping_o && !profile_select_0_i && $stable(profile_select_0_i)
            |=> $stable(freq_word_o);
    endproperty
    a_hold_bottom: assert property (p_hold_bottom) else $error("start frequency not held");
    property p_freeze;
        !ce_i |=> $stable(freq_word_o) && $stable(sync_output_clock_o) && $stable(sweeping_o);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved with enable low");
    c_rise: cover property (sw_en && $rose(profile_select_0_i) ##2 sweeping_o);
    c_nd_fall: cover property (sw_en && nd && $fell(profile_select_0_i) && sweeping_o);
    c_freeze: cover property (!ce_i && sweeping_o);
endmodule
bind lfs_sweep lfs_sweep_checker u_chk (
    .clk_sys_i                  (clk_sys_i),
    .reset_i                    (reset_i),
    .ce_i                       (ce_i),
    .reg_addr_i                 (reg_addr_i),
    .reg_wdata_i                (reg_wdata_i),
    .reg_wr_i                   (reg_wr_i),
    .reg_rd_i                   (reg_rd_i),
    .reg_rdata_o                (reg_rdata_o),
    .profile_select_0_i         (profile_select_0_i),
    .register_transfer_strobe_i (register_transfer_strobe_i),
    .sync_output_clock_o        (sync_output_clock_o),
    .freq_word_o                (freq_word_o),
    .sweeping_o                 (sweeping_o)
);

// ---- testbench/lfs_host_model.sv ----
`timescale 1ns/1ps
module lfs_host_model (
    input  wire logic clk_sys_i,
    output logic      profile_select_0_o,
    output logic      profile_select_1_o,
    output logic      strobe_o
);
    assign profile_select_1_o = 1'b0;
    initial begin
        profile_select_0_o = 1'b0;
        strobe_o           = 1'b0;
    end
    // Held two or more cycles: a one-cycle pulse can miss the sampling phase
    task automatic pulse_strobe(input int hold);
        @(posedge clk_sys_i);
        strobe_o <= 1'b1;
        repeat (hold) @(posedge clk_sys_i);
        strobe_o <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
    endtask
    task automatic set_pin(input logic level);
        @(posedge clk_sys_i);
        profile_select_0_o <= level;
    endtask
endmodule

// ---- testbench/linear_frequency_sweep_test.sv ----
`timescale 1ns/1ps
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module linear_frequency_sweep_test
    import lfs_pkg::*;
;
    logic                  clk_sys_i;
    logic                  reset_i;
    logic                  ce_i;
    logic [LFS_ADDR_W-1:0] reg_addr_i;
    logic [LFS_DATA_W-1:0] reg_wdata_i;
    logic                  reg_wr_i;
    logic                  reg_rd_i;
    logic [LFS_DATA_W-1:0] reg_rdata_o;
    logic                  pin;
    logic                  strobe;
    logic                  sync_clk;
    logic [LFS_DATA_W-1:0] freq_word_o;
    logic                  sweeping_o;
    int                    n_mismatch;
    int                    cmp_count;
    int                    cyc;
    lfs_sweep dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .ce_i(ce_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .profile_select_0_i(pin), .register_transfer_strobe_i(strobe), .sync_output_clock_o(sync_clk),
        .freq_word_o(freq_word_o), .sweeping_o(sweeping_o));
    lfs_host_model host (.clk_sys_i(clk_sys_i), .profile_select_0_o(pin), .profile_select_1_o(),
        .strobe_o(strobe));
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i    <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i   <= 1'b0;
        #1;
        `CHK(reg_rdata_o, e)
    endtask
    // Counts edges until the word shows the target; the count pins down the pace
    task automatic sweep_wait(input logic [31:0] target, input int exp_n);
        int n;
        n = 0;
        do begin
            @(posedge clk_sys_i);
            #1;
            n++;
        end while (freq_word_o !== target && n < 80);
        `CHK(n, exp_n)
    endtask
    task automatic settle_check(input logic [31:0] e);
        repeat (6) @(posedge clk_sys_i);
        #1;
        `CHK(freq_word_o, e)
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            n_mismatch++;
            give_verdict();
        end
    end
    initial begin
        reset_i     = 1'b1;
        ce_i        = 1'b1;
        reg_addr_i  = '0;
        reg_wdata_i = '0;
        reg_wr_i    = 1'b0;
        reg_rd_i    = 1'b0;
        n_mismatch  = 0;
        cmp_count   = 0;
        cyc         = 0;
        repeat (3) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        rd(LFS_REG_CTRL, 32'h0000_0000);
        rd(LFS_REG_FREQ, 32'h0000_0000);
        rd(LFS_REG_STATUS, 32'h0000_0000);
        $display("test reset done");
        wr(LFS_REG_START, 32'h0000_0100);
        wr(LFS_REG_END, 32'h0000_0150);
        wr(LFS_REG_RSTEP, 32'h0000_0010);
        wr(LFS_REG_FSTEP, 32'h0000_0020);
        wr(LFS_REG_RATES, 32'hFFFF_0203);
        wr(4'hA, 32'h1234_5678);
        wr(LFS_REG_FREQ, 32'h0000_0999);
        rd(LFS_REG_RATES, 32'h0000_0203);
        rd(4'hA, 32'h0000_0000);
        host.pulse_strobe(2);
        host.set_pin(1'b1);
        settle_check(32'h0000_0100);
        `CHK(sweeping_o, 1'b0)
        rd(LFS_REG_FREQ, 32'h0000_0100);
        host.set_pin(1'b0);
        $display("test single tone done");
        wr(LFS_REG_CTRL, 32'h0020_0000);
        host.pulse_strobe(5);
        rd(LFS_REG_STATUS, 32'h0000_0004);
        host.set_pin(1'b1);
        sweep_wait(32'h0000_0110, 4);
        @(posedge clk_sys_i);
        ce_i <= 1'b0;
        repeat (5) @(posedge clk_sys_i);
        ce_i <= 1'b1;
        sweep_wait(32'h0000_0150, 11);
        settle_check(32'h0000_0150);
        rd(LFS_REG_STATUS, 32'h0000_0002);
        $display("test rise done");
        host.set_pin(1'b0);
        sweep_wait(32'h0000_0130, 3);
        sweep_wait(32'h0000_0100, 4);
        settle_check(32'h0000_0100);
        rd(LFS_REG_STATUS, 32'h0000_0004);
        $display("test fall done");
        wr(LFS_REG_CTRL, 32'h0020_0004);
        host.pulse_strobe(2);
        wr(LFS_REG_START, 32'h0000_00F0);
        host.set_pin(1'b1);
        sweep_wait(32'h0000_0120, 7);
        host.set_pin(1'b0);
        sweep_wait(32'h0000_0140, 5);
        sweep_wait(32'h0000_0100, 3);
        settle_check(32'h0000_0100);
        `CHK(sweeping_o, 1'b0)
        rd(LFS_REG_START, 32'h0000_00F0);
        $display("test no dwell done");
        wr(LFS_REG_CTRL, 32'h0020_8000);
        wr(LFS_REG_RATES, 32'h0000_0208);
        host.pulse_strobe(2);
        host.set_pin(1'b1);
        // Mid-ramp strobe restarts the 8-cycle wait, so no step yet
        host.pulse_strobe(2);
        repeat (4) @(posedge clk_sys_i);
        #1;
        `CHK(freq_word_o, 32'h0000_0100)
        `CHK(sweeping_o, 1'b1)
        $display("test forced load done");
        give_verdict();
    end
endmodule
